/* logic/uifc_pkg.sv */
package uifc_pkg;
  // register byte addresses; the status read and the fifo control write share one word
  localparam logic [7:0] ADDR_IE = 8'h04;
  localparam logic [7:0] ADDR_STAT_FC = 8'h08;
  localparam logic [7:0] ADDR_EF = 8'h0c;
  localparam logic [7:0] ADDR_EMS = 8'h10;
  // reset values
  localparam logic [7:0] IE_RST = 8'h00;
  localparam logic [7:0] EF_RST = 8'h00;
  localparam logic [7:0] EMS_RST = 8'h00;
  localparam logic [1:0] TRIG_RST = 2'h0;
  // interrupt_enable fields
  localparam int IE_RX = 0;
  localparam int IE_TX = 1;
  localparam int IE_LS = 2;
  localparam int IE_MS = 3;
  localparam int IE_SLEEP = 4;
  localparam int IE_XOFF = 5;
  localparam int IE_RTS = 6;
  localparam int IE_CTS = 7;
  // fifo_control fields
  localparam int FC_EN = 0;
  localparam int FC_RXRST = 1;
  localparam int FC_TXRST = 2;
  localparam int FC_WAKE = 3;
  localparam int FC_TXTRIG = 4;
  localparam int FC_RXTRIG = 6;
  // enhanced_function and enhanced_mode_select fields
  localparam int EF_ENH = 4;
  localparam int EF_ARTS = 6;
  localparam int EF_ACTS = 7;
  localparam int EMS_ERRFIFO = 6;
  // status codes, bits 5..0
  localparam logic [5:0] CODE_LS = 6'h06;
  localparam logic [5:0] CODE_TO = 6'h0c;
  localparam logic [5:0] CODE_RX = 6'h04;
  localparam logic [5:0] CODE_TX = 6'h02;
  localparam logic [5:0] CODE_MS = 6'h00;
  localparam logic [5:0] CODE_XO = 6'h10;
  localparam logic [5:0] CODE_CR = 6'h20;
  localparam logic [5:0] CODE_NONE = 6'h01;
  // trigger tables, indexed by the two-bit field
  localparam logic [3:0][5:0] RX_TRIG = {6'h1c, 6'h18, 6'h10, 6'h08};
  localparam logic [3:0][5:0] TX_TRIG = {6'h1e, 6'h18, 6'h08, 6'h10};
  localparam logic [5:0] NOFIFO_TRIG = 6'h01;
  // receive time-out: character times plus bit times
  localparam logic [7:0] TO_CHARS = 8'h04;
  localparam logic [7:0] TO_BITS = 8'h0c;

  typedef struct packed {
    logic overrun;
    logic err_hold;
    logic err_fifo;
    logic rx_char;
    logic xon;
    logic xoff;
    logic special;
    logic wake;
    logic line_rd;
    logic modem_rd;
    logic rxhold_rd;
    logic txhold_wr;
  } uifc_ev_type;
endpackage : uifc_pkg

/* logic/uifc_top.sv */
// The register addresses and the APB slave port were decided locally.
module uifc_top
  import uifc_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // uart core status, same clock
  input wire uifc_ev_type ev_i,
  input wire logic [5:0] rx_level_i,
  input wire logic [5:0] tx_level_i,
  input wire logic [3:0] modem_bits_i,
  input wire logic rts_pin_i,
  input wire logic bit_tick_i,
  input wire logic [3:0] char_bits_i,
  // pin from the far side
  input wire logic cts_pin_i,
  // controls and interrupt
  output logic int_o,
  output logic fifo_en_o,
  output logic rx_fifo_rst_o,
  output logic tx_fifo_rst_o,
  output logic [5:0] rx_trig_o,
  output logic [5:0] tx_trig_o,
  output logic sleep_en_o,
  output logic auto_rts_o,
  output logic auto_cts_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (sys_rst_i);

  logic [7:0] ie_q, ef_q, ems_q, ie_eff;
  logic fifo_en_q, wake_en_q, rx_rst_q, tx_rst_q;
  logic [5:0] rx_trig_q, tx_trig_q;
  logic pready_q, pslverr_q, int_q, sleep_q;
  logic [31:0] prdata_q;
  logic [5:0] rep_code_q, stat_code;
  logic ls_q, to_q, tx_q, xo_q, spc_q, cr_q, wk_q;
  logic [5:0] tx_prev_q, rx_thr, tx_thr;
  logic tx_over_q, txie_prev_q;
  logic cts_s1_q, cts_s2_q, cts_s3_q, rts_prev_q;
  logic [7:0] to_cnt_q, to_lim;
  logic acc, done, wr, stat_rd, mapped, fc_wr;
  logic p_ls, p_to, p_rx, p_tx, p_ms, p_xo, p_cr, p_wk, any_p;
  logic tx_set, to_set, cts_rise, rts_rise;
  logic [31:0] rd_mux;

  // apb: one wait state, so read data and the reported code are both flopped
  assign acc = psel_i & penable_i;
  assign done = acc & pready_q;
  assign wr = done & pwrite_i;
  assign stat_rd = done & ~pwrite_i & (paddr_i == ADDR_STAT_FC);
  assign fc_wr = wr & (paddr_i == ADDR_STAT_FC);
  assign mapped = (paddr_i == ADDR_IE) | (paddr_i == ADDR_STAT_FC) | (paddr_i == ADDR_EF) | (paddr_i == ADDR_EMS);

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (paddr_i)
      ADDR_IE: rd_mux = {24'h00_0000, ie_q};
      ADDR_STAT_FC: rd_mux = {24'h00_0000, {2{fifo_en_q}}, stat_code};
      ADDR_EF: rd_mux = {24'h00_0000, ef_q};
      ADDR_EMS: rd_mux = {24'h00_0000, ems_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      rep_code_q <= CODE_NONE;
    end
    else
    begin
      pready_q <= acc & ~pready_q;
      pslverr_q <= acc & ~pready_q & ~mapped;
      if (acc & ~pready_q & ~pwrite_i)
      begin
        prdata_q <= rd_mux;
        rep_code_q <= stat_code;
      end
    end
  end

  // software registers
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      ie_q <= IE_RST;
      ef_q <= EF_RST;
      ems_q <= EMS_RST;
    end
    else if (wr)
    begin
      if (paddr_i == ADDR_IE)
        ie_q <= pwdata_i[7:0];
      if (paddr_i == ADDR_EF)
        ef_q <= pwdata_i[7:0];
      if (paddr_i == ADDR_EMS)
        ems_q <= pwdata_i[7:0];
    end
  end

  // upper enables count only in enhanced mode
  assign ie_eff = {ie_q[7:4] & {4{ef_q[EF_ENH]}}, ie_q[3:0]};

  // sleep enable is flopped so the output never shows the gate of two registers
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      sleep_q <= 1'b0;
    else
      sleep_q <= ie_eff[IE_SLEEP];
  end

  // fifo control: a write without bit 0 only turns the fifos off
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      fifo_en_q <= 1'b0;
      wake_en_q <= 1'b0;
      rx_trig_q <= RX_TRIG[TRIG_RST];
      tx_trig_q <= TX_TRIG[TRIG_RST];
      rx_rst_q <= 1'b0;
      tx_rst_q <= 1'b0;
    end
    else
    begin
      rx_rst_q <= fc_wr & pwdata_i[FC_EN] & pwdata_i[FC_RXRST];
      tx_rst_q <= fc_wr & pwdata_i[FC_EN] & pwdata_i[FC_TXRST];
      if (fc_wr)
      begin
        fifo_en_q <= pwdata_i[FC_EN];
        if (pwdata_i[FC_EN])
        begin
          rx_trig_q <= RX_TRIG[pwdata_i[FC_RXTRIG +: 2]];
          if (ef_q[EF_ENH])
          begin
            tx_trig_q <= TX_TRIG[pwdata_i[FC_TXTRIG +: 2]];
            wake_en_q <= pwdata_i[FC_WAKE];
          end
        end
      end
    end
  end

  // trigger levels; without fifos a single character is the threshold
  assign rx_thr = fifo_en_q ? rx_trig_q : NOFIFO_TRIG;
  assign tx_thr = fifo_en_q ? tx_trig_q : NOFIFO_TRIG;

  // cts comes from a pin: two flops, then an edge flop
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      cts_s1_q <= 1'b0;
      cts_s2_q <= 1'b0;
      cts_s3_q <= 1'b0;
      rts_prev_q <= 1'b0;
    end
    else
    begin
      cts_s1_q <= cts_pin_i;
      cts_s2_q <= cts_s1_q;
      cts_s3_q <= cts_s2_q;
      rts_prev_q <= rts_pin_i;
    end
  end

  assign cts_rise = cts_s2_q & ~cts_s3_q & ef_q[EF_ACTS] & ie_eff[IE_CTS];
  assign rts_rise = rts_pin_i & ~rts_prev_q & ef_q[EF_ARTS] & ie_eff[IE_RTS];

  // line status: set wins over the clearing read
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      ls_q <= 1'b0;
    else if (ev_i.overrun | (ems_q[EMS_ERRFIFO] ? ev_i.err_fifo : ev_i.err_hold))
      ls_q <= 1'b1;
    else if (ev_i.line_rd)
      ls_q <= 1'b0;
  end

  // receive time-out timer counts bit times; restarts on every new character or read
  assign to_lim = 8'((TO_CHARS * {4'h0, char_bits_i}) + TO_BITS);
  assign to_set = bit_tick_i & (to_cnt_q == to_lim - 8'h01) & (rx_level_i != 6'h00);

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      to_cnt_q <= 8'h00;
    else if (ev_i.rx_char | ev_i.rxhold_rd | (rx_level_i == 6'h00) | to_q)
      to_cnt_q <= 8'h00;
    else if (bit_tick_i)
      to_cnt_q <= to_cnt_q + 8'h01;
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      to_q <= 1'b0;
    else if (to_set)
      to_q <= 1'b1;
    else if (ev_i.rxhold_rd)
      to_q <= 1'b0;
  end

  // transmit ready: falling below trigger, or empty when the reload stayed at or under it
  assign tx_set = ((tx_prev_q >= tx_thr) & (tx_level_i < tx_thr))
    | ((tx_level_i == 6'h00) & (tx_prev_q != 6'h00) & ~tx_over_q)
    | (ie_q[IE_TX] & ~txie_prev_q & (tx_level_i == 6'h00));

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      tx_prev_q <= 6'h00;
      tx_over_q <= 1'b0;
      txie_prev_q <= 1'b0;
      tx_q <= 1'b0;
    end
    else
    begin
      tx_prev_q <= tx_level_i;
      txie_prev_q <= ie_q[IE_TX];
      if (tx_level_i > tx_thr)
        tx_over_q <= 1'b1;
      else if (tx_level_i == 6'h00)
        tx_over_q <= 1'b0;
      if (tx_set)
        tx_q <= 1'b1;
      else if (ev_i.txhold_wr | (stat_rd & (rep_code_q == CODE_TX)))
        tx_q <= 1'b0;
    end
  end

  // character match, flow-control edge and wake flags
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      xo_q <= 1'b0;
      spc_q <= 1'b0;
      cr_q <= 1'b0;
      wk_q <= 1'b0;
    end
    else
    begin
      if (ev_i.xon | ev_i.xoff)
        xo_q <= 1'b1;
      else if (stat_rd & (rep_code_q == CODE_XO))
        xo_q <= 1'b0;
      if (ev_i.special)
        spc_q <= 1'b1;
      else if (ev_i.rx_char | (stat_rd & (rep_code_q == CODE_XO)))
        spc_q <= 1'b0;
      if (cts_rise | rts_rise)
        cr_q <= 1'b1;
      else if (ev_i.modem_rd)
        cr_q <= 1'b0;
      if (ev_i.wake & wake_en_q)
        wk_q <= 1'b1;
      else if (stat_rd & (rep_code_q == CODE_NONE))
        wk_q <= 1'b0;
    end
  end

  // pending sources after masking
  assign p_ls = ls_q & ie_eff[IE_LS];
  assign p_to = to_q & ie_eff[IE_RX];
  assign p_rx = (rx_level_i >= rx_thr) & ie_eff[IE_RX];
  assign p_tx = tx_q & ie_eff[IE_TX];
  assign p_ms = (|modem_bits_i) & ie_eff[IE_MS];
  assign p_xo = (xo_q | spc_q) & ie_eff[IE_XOFF];
  assign p_cr = cr_q;
  assign p_wk = wk_q;
  assign any_p = p_ls | p_to | p_rx | p_tx | p_ms | p_xo | p_cr | p_wk;

  // only the highest pending source other than wake is shown; the rest wait their turn
  always_comb
  begin
    if (p_ls)
      stat_code = CODE_LS;
    else if (p_to)
      stat_code = CODE_TO;
    else if (p_rx)
      stat_code = CODE_RX;
    else if (p_tx)
      stat_code = CODE_TX;
    else if (p_ms)
      stat_code = CODE_MS;
    else if (p_xo)
      stat_code = CODE_XO;
    else if (p_cr)
      stat_code = CODE_CR;
    else
      stat_code = CODE_NONE;
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      int_q <= 1'b0;
    else
      int_q <= any_p;
  end

  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign int_o = int_q;
  assign fifo_en_o = fifo_en_q;
  assign rx_fifo_rst_o = rx_rst_q;
  assign tx_fifo_rst_o = tx_rst_q;
  assign rx_trig_o = rx_trig_q;
  assign tx_trig_o = tx_trig_q;
  assign sleep_en_o = sleep_q;
  assign auto_rts_o = ef_q[EF_ARTS];
  assign auto_cts_o = ef_q[EF_ACTS];

  AST_OVR_LS: assert property (ev_i.overrun |=> ~ie_q[IE_LS] | (stat_code == CODE_LS))
    else $error("overrun did not raise line status");
  AST_ERR_SEL: assert property (ev_i.err_fifo & ems_q[EMS_ERRFIFO] |=> ls_q)
    else $error("error at fifo entry missed");
  AST_ENH_GATE: assert property (~ef_q[EF_ENH] |-> (ie_eff[7:4] == 4'h0) ##1 ~sleep_en_o)
    else $error("upper enables active outside enhanced mode");
  AST_CTS_EDGE: assert property ($rose(cts_s2_q) & ef_q[EF_ACTS] & ie_eff[IE_CTS] |=> cr_q)
    else $error("cts rising edge lost");
  AST_NONE_CODE: assert property (~any_p |-> stat_code == CODE_NONE)
    else $error("idle code wrong");
  AST_RX_CODE: assert property (~p_ls & ~p_to & p_rx |-> stat_code == CODE_RX)
    else $error("data ready code wrong");
  AST_TO_CLR: assert property (ev_i.rxhold_rd & ~to_set |=> ~to_q)
    else $error("time-out not cleared by holding read");
  AST_THR_CLR: assert property (ev_i.txhold_wr & ~tx_set |=> ~tx_q)
    else $error("transmit ready not cleared by write");
  AST_FIFO_BITS: assert property (stat_rd |-> prdata_o[7:6] == {2{fifo_en_q}})
    else $error("fifo enable bits wrong");
  AST_FC_IGNORE: assert property (fc_wr & ~pwdata_i[FC_EN]
    |=> ~rx_fifo_rst_o & ~tx_fifo_rst_o & $stable(rx_trig_q))
    else $error("fifo control accepted without enable");
  AST_RXRST: assert property (fc_wr & pwdata_i[FC_EN] & pwdata_i[FC_RXRST]
    |=> rx_fifo_rst_o ##1 ~rx_fifo_rst_o)
    else $error("receive fifo reset not a single pulse");
  AST_TXRST: assert property (fc_wr & pwdata_i[FC_EN] & pwdata_i[FC_TXRST]
    |=> tx_fifo_rst_o ##1 ~tx_fifo_rst_o)
    else $error("transmit fifo reset not a single pulse");
  AST_INT_OUT: assert property (any_p |=> int_o)
    else $error("interrupt output missing");
endmodule : uifc_top

/* bench/uifc_host_model.sv */
module uifc_host_model (
  // clock
  input wire logic mclk_i,
  // apb master
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [7:0] paddr_o,
  output logic [31:0] pwdata_o,
  input wire logic [31:0] prdata_i,
  input wire logic pready_i,
  input wire logic pslverr_i
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 8'h00;
    pwdata_o = 32'h0;
  end

  // entered just after a rising edge; the request is held until pready is sampled
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rdat, output logic err, output logic ok);
    int n;
    n = 0;
    psel_o <= 1'b1;
    pwrite_o <= wr;
    paddr_o <= a;
    pwdata_o <= wd;
    @(posedge mclk_i);
    penable_o <= 1'b1;
    @(posedge mclk_i);
    while (pready_i !== 1'b1 && n < 20)
    begin
      @(posedge mclk_i);
      n++;
    end
    ok = (pready_i === 1'b1);
    rdat = prdata_i;
    err = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    // one idle edge so a following call never reassigns in the same step
    @(posedge mclk_i);
  endtask : xfer
endmodule : uifc_host_model

/* bench/test_uart_interrupt_and_fifo_control.sv */
module test_uart_interrupt_and_fifo_control;
  import uifc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [11:0] OVR = 12'h800;
  localparam logic [11:0] EHOLD = 12'h400;
  localparam logic [11:0] EFIFO = 12'h200;
  localparam logic [11:0] RXC = 12'h100;
  localparam logic [11:0] XON = 12'h080;
  localparam logic [11:0] SPEC = 12'h020;
  localparam logic [11:0] WAKE = 12'h010;
  localparam logic [11:0] LSRD = 12'h008;
  localparam logic [11:0] MSRD = 12'h004;
  localparam logic [11:0] RHRD = 12'h002;
  localparam logic [11:0] THRW = 12'h001;
  localparam logic [7:0] ST = ADDR_STAT_FC;

  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, perr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  uifc_ev_type ev = '0;
  logic [5:0] rx_lvl = 6'h00;
  logic [5:0] tx_lvl = 6'h05;
  logic [3:0] modem_status = 4'h0;
  logic [3:0] cbits = 4'h8;
  logic rts = 1'b0;
  logic cts = 1'b0;
  logic tick = 1'b0;
  logic intr, fen, rxr, txr, slp, arts, acts;
  logic [5:0] rxt, txt;
  int n_fail = 0;
  int checked = 0;
  int n_rxr = 0;
  int n_txr = 0;
  int rx_tab[4] = '{8, 16, 24, 28};
  int tx_tab[4] = '{16, 8, 24, 30};

  always #20 mclk_i = ~mclk_i;

  always @(posedge mclk_i)
  begin
    if (rxr === 1'b1)
      n_rxr <= n_rxr + 1;
    if (txr === 1'b1)
      n_txr <= n_txr + 1;
  end

  uifc_host_model i_uifc_host_model (.mclk_i(mclk_i), .psel_o(psel), .penable_o(penable),
    .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata),
    .pready_i(pready), .pslverr_i(pslverr));

  uifc_top i_uifc_top (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .ev_i(ev), .rx_level_i(rx_lvl), .tx_level_i(tx_lvl), .modem_bits_i(modem_status),
    .rts_pin_i(rts), .bit_tick_i(tick), .char_bits_i(cbits), .cts_pin_i(cts), .int_o(intr),
    .fifo_en_o(fen), .rx_fifo_rst_o(rxr), .tx_fifo_rst_o(txr), .rx_trig_o(rxt), .tx_trig_o(txt),
    .sleep_en_o(slp), .auto_rts_o(arts), .auto_cts_o(acts));

  task automatic finish_test();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : cyc

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    logic ok;
    i_uifc_host_model.xfer(w, a, d, q, perr, ok);
    if (!ok)
    begin
      n_fail++;
      finish_test();
    end
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask : rd

  // int_o is settled when this returns
  task automatic pulse(input logic [11:0] e);
    ev <= e;
    @(posedge mclk_i);
    ev <= '0;
    cyc(2);
  endtask : pulse

  task automatic s_reset();
    rd(ST, 32'h01);
    rd(ADDR_IE, 32'h00);
    chk(rxt, 32'd8);
    chk(txt, 32'd16);
    rd(8'h3c, 32'h0);
    chk(perr, 32'h1);
  endtask : s_reset

  task automatic s_line();
    wr(ADDR_IE, 32'h04);
    pulse(OVR);
    chk(intr, 32'h1);
    rd(ST, 32'h06);
    pulse(LSRD);
    chk(intr, 32'h0);
    pulse(EFIFO);
    rd(ST, 32'h01);
    pulse(EHOLD);
    rd(ST, 32'h06);
    pulse(LSRD);
    wr(ADDR_EMS, 32'h40);
    pulse(EFIFO);
    rd(ST, 32'h06);
    pulse(LSRD);
    wr(ADDR_IE, 32'h00);
    pulse(OVR);
    rd(ST, 32'h01);
    pulse(LSRD);
  endtask : s_line

  task automatic s_prio();
    rx_lvl <= 6'd1;
    modem_status <= 4'h1;
    wr(ADDR_IE, 32'h0f);
    pulse(OVR);
    rd(ST, 32'h06);
    rd(ST, 32'h06);
    pulse(LSRD);
    rd(ST, 32'h04);
    rx_lvl <= 6'd0;
    cyc(2);
    rd(ST, 32'h00);
    tx_lvl <= 6'd0;
    cyc(2);
    rd(ST, 32'h02);
    rd(ST, 32'h00);
    modem_status <= 4'h0;
    pulse(MSRD);
    rd(ST, 32'h01);
    wr(ADDR_IE, 32'h0d);
    wr(ADDR_IE, 32'h0f);
    rd(ST, 32'h02);
    wr(ADDR_IE, 32'h0d);
    wr(ADDR_IE, 32'h0f);
    pulse(THRW);
    rd(ST, 32'h01);
  endtask : s_prio

  task automatic s_fifo();
    wr(ST, 32'h06);
    cyc(2);
    chk(n_rxr, 32'd0);
    chk(fen, 32'h0);
    wr(ST, 32'h07);
    cyc(4);
    chk(n_rxr, 32'd1);
    chk(n_txr, 32'd1);
    chk(fen, 32'h1);
    rd(ST, 32'hc1);
    for (int k = 0; k < 4; k++)
    begin
      wr(ST, {24'h0, 2'(k), 6'h31});
      chk(rxt, 32'(rx_tab[k]));
      chk(txt, 32'd16);
    end
    wr(ADDR_EF, 32'h10);
    for (int k = 0; k < 4; k++)
    begin
      wr(ST, {26'h0, 2'(k), 4'h1});
      chk(txt, 32'(tx_tab[k]));
    end
    // reload stays under the trigger of 30, so emptying alone must fire
    tx_lvl <= 6'd5;
    cyc(2);
    tx_lvl <= 6'd0;
    cyc(2);
    rd(ST, 32'hc2);
    wr(ST, 32'h00);
    rd(ST, 32'h01);
  endtask : s_fifo

  task automatic s_enh();
    wr(ADDR_EF, 32'h00);
    wr(ADDR_IE, 32'hf0);
    chk(slp, 32'h0);
    cts <= 1'b1;
    cyc(6);
    rd(ST, 32'h01);
    cts <= 1'b0;
    wr(ADDR_EF, 32'hd0);
    wr(ADDR_IE, 32'hf0);
    chk({slp, arts, acts}, 32'h7);
    cts <= 1'b1;
    cyc(6);
    rd(ST, 32'h20);
    rd(ST, 32'h20);
    pulse(MSRD);
    rd(ST, 32'h01);
    rts <= 1'b1;
    cyc(3);
    rd(ST, 32'h20);
    pulse(MSRD);
    pulse(XON);
    rd(ST, 32'h10);
    rd(ST, 32'h01);
    pulse(SPEC);
    pulse(RXC);
    rd(ST, 32'h01);
    wr(ST, 32'h09);
    pulse(WAKE);
    chk(intr, 32'h1);
    rd(ST, 32'hc1);
    cyc(2);
    chk(intr, 32'h0);
  endtask : s_enh

  // limit is four frames of two bits plus twelve, so twenty ticks
  task automatic s_tmo();
    wr(ADDR_IE, 32'h01);
    cbits <= 4'h2;
    rx_lvl <= 6'd1;
    tick <= 1'b1;
    pulse(RXC);
    rd(ST, 32'hc1);
    cyc(25);
    rd(ST, 32'hcc);
    pulse(RHRD);
    rd(ST, 32'hc1);
    tick <= 1'b0;
  endtask : s_tmo

  initial
  begin
    cyc(10);
    sys_rst_i <= 1'b0;
    @(posedge mclk_i);
    s_reset();
    s_line();
    s_prio();
    s_fifo();
    s_enh();
    s_tmo();
    finish_test();
  end
endmodule : test_uart_interrupt_and_fifo_control
